/* File: include/hbridge_pkg.sv */
`default_nettype none
package hbridge_pkg;
    localparam int CLK_MHZ = 50;
    // constant off time of the current limiter, in us
    localparam int OFF_TIME_US = 20;
    localparam int OFF_CYCLES = OFF_TIME_US * CLK_MHZ;
    localparam int OFF_W = 11;
    // blanking after each output transition, in ns
    localparam int BLANK_NS = 2000;
    localparam int BLANK_CYCLES = (BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int BLANK_W = 8;
    localparam logic [OFF_W-1:0] OFF_RESET = 11'h000;
    localparam logic [BLANK_W-1:0] BLANK_RESET = 8'h00;

    typedef enum logic [1:0] {
        ST_SLEEP = 2'b00,
        ST_RUN = 2'b01,
        ST_LATCHED = 2'b11,
        ST_DISABLED = 2'b10
    } mode_t;

    typedef struct packed {
        logic polarityInA;
        logic polarityInB;
        logic disableHighIn;
        logic enableSleepLowIn;
    } ctrl_t;

    typedef struct packed {
        logic underVoltage;
        logic shortCircuit;
        logic overTemp;
        logic tempBelowRestart;
        logic tempAboveFoldback;
        logic currentAtNormalLimit;
        logic currentAtReducedLimit;
    } sense_t;

    // one half-bridge: level and output enable
    typedef struct packed {
        logic level;
        logic drive;
    } half_t;
endpackage
`default_nettype wire

/* File: core/input_sync.sv */
`default_nettype none
module input_sync (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic async,
    output logic synced
);
    typedef struct packed {
        logic first;
        logic second;
    } sync_t;
    sync_t state;
    sync_t next_state;
    always_comb begin
        next_state.first = async;
        next_state.second = state.first;
    end
    // both flops reset low, so every pin reads low until sampled
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    assign synced = state.second;
endmodule
`default_nettype wire

/* File: core/hbridge_gate_control.sv */
// Functional notes
// R1: enabled, not disabled, no fault: outputs follow polarity inputs, flag high.
// R2: disable high tri-states and pulls flag low; enable low sleeps, flag high.
// R3: under-voltage tri-states, flag low; recovery restores without host action.
// R4: short or over-temperature latches outputs off and flag low.
// R5: disable falling or enable rising edge clears latch; host must give one.
// R6: after thermal latch, restart only once temperature below restart point.
// R7: power cycle (reset) clears any latched fault and flag.
// R8: current limit tri-states outputs for fixed 20 us, then resumes.
// R9: above 160 C the reduced 4.2 A limit replaces normal limit.
// R10: over-temperature trip above 175 C causes latched shutdown.
// R11: host avoids prolonged foldback operation; above 150 C under 30 s.
// R12: blanking timer at each output transition masks the current limit.
// R13: enable input undriven reads as low, so device sleeps.
// R14: control inputs synchronised before clearing edges are detected.
`default_nettype none
module hbridge_gate_control (
    input wire logic mclk,
    input wire logic resetn,
    input wire hbridge_pkg::ctrl_t ctrlIn,
    input wire hbridge_pkg::sense_t sense,
    output hbridge_pkg::half_t bridgeOutA,
    output hbridge_pkg::half_t bridgeOutB,
    output logic faultFlagLowOut,
    output logic faultFlagLowOe,
    output logic sleepMode,
    output logic limitOff,
    output logic thermalLimitEvent
);
    typedef struct packed {
        hbridge_pkg::mode_t mode;
        logic thermalLatch;
        logic prevDisable;
        logic prevEnable;
        logic [hbridge_pkg::OFF_W-1:0] offCount;
        logic [hbridge_pkg::BLANK_W-1:0] blankCount;
        logic prevA;
        logic prevB;
        logic prevDrive;
        hbridge_pkg::half_t outA;
        hbridge_pkg::half_t outB;
        logic flagLow;
        logic awake;
        logic offActive;
        logic thermalEvent;
    } state_t;

    state_t state;
    state_t next_state;
    logic syncA;
    logic syncB;
    logic syncDis;
    logic syncEn;
    logic clearEdge;
    logic limitHit;
    logic wantDrive;
    logic hold;

    // R14: synchronise inputs
    input_sync syncInA (
        .mclk(mclk),
        .resetn(resetn),
        .async(ctrlIn.polarityInA),
        .synced(syncA)
    );
    input_sync syncInB (
        .mclk(mclk),
        .resetn(resetn),
        .async(ctrlIn.polarityInB),
        .synced(syncB)
    );
    input_sync syncInDis (
        .mclk(mclk),
        .resetn(resetn),
        .async(ctrlIn.disableHighIn),
        .synced(syncDis)
    );
    // R13: enable resets to low, a floating pin is modelled as low outside
    input_sync syncInEn (
        .mclk(mclk),
        .resetn(resetn),
        .async(ctrlIn.enableSleepLowIn),
        .synced(syncEn)
    );

    // R5: clearing edges
    assign clearEdge = (state.prevDisable && !syncDis) ||
                       (!state.prevEnable && syncEn);

    // R9: foldback selects reduced limit when hot
    assign limitHit = sense.tempAboveFoldback ?
                      sense.currentAtReducedLimit :
                      sense.currentAtNormalLimit;

    // R6: thermal latch holds until temperature is low enough
    assign hold = state.thermalLatch && !sense.tempBelowRestart;

    always_comb begin
        next_state = state;
        next_state.prevDisable = syncDis;
        next_state.prevEnable = syncEn;
        wantDrive = 1'b0;
        if (state.offCount != hbridge_pkg::OFF_RESET) begin
            next_state.offCount = state.offCount - 11'h001;
        end
        if (state.blankCount != hbridge_pkg::BLANK_RESET) begin
            next_state.blankCount = state.blankCount - 8'h01;
        end
        case (state.mode)
            hbridge_pkg::ST_SLEEP: begin
                if (syncEn) begin
                    next_state.mode = syncDis ? hbridge_pkg::ST_DISABLED
                                              : hbridge_pkg::ST_RUN;
                end
            end
            hbridge_pkg::ST_RUN: begin
                // R4: R10: short or thermal trip latches off
                if (sense.shortCircuit || sense.overTemp) begin
                    next_state.mode = hbridge_pkg::ST_LATCHED;
                    next_state.thermalLatch = sense.overTemp;
                end else if (!syncEn) begin
                    next_state.mode = hbridge_pkg::ST_SLEEP;
                end else if (syncDis) begin
                    next_state.mode = hbridge_pkg::ST_DISABLED;
                end else begin
                    wantDrive = 1'b1;
                end
            end
            hbridge_pkg::ST_DISABLED: begin
                if (sense.shortCircuit || sense.overTemp) begin
                    next_state.mode = hbridge_pkg::ST_LATCHED;
                    next_state.thermalLatch = sense.overTemp;
                end else if (!syncEn) begin
                    next_state.mode = hbridge_pkg::ST_SLEEP;
                end else if (!syncDis) begin
                    next_state.mode = hbridge_pkg::ST_RUN;
                end
            end
            hbridge_pkg::ST_LATCHED: begin
                // sleep first: a clear while asleep must not drive
                if (!syncEn) begin
                    next_state.mode = hbridge_pkg::ST_SLEEP;
                end else if (clearEdge) begin
                    // R5: clearing edge releases latch
                    next_state.mode = syncDis ? hbridge_pkg::ST_DISABLED
                                              : hbridge_pkg::ST_RUN;
                end
            end
            default: begin
                next_state.mode = hbridge_pkg::ST_SLEEP;
            end
        endcase
        if (next_state.mode != hbridge_pkg::ST_LATCHED &&
            state.mode == hbridge_pkg::ST_LATCHED) begin
            next_state.thermalLatch = state.thermalLatch;
        end
        // R3: under-voltage overrides drive, no latch
        if (sense.underVoltage) begin
            wantDrive = 1'b0;
        end
        // R6: hot restart waits until cool
        if (hold) begin
            wantDrive = 1'b0;
        end else if (next_state.mode != hbridge_pkg::ST_LATCHED) begin
            // next mode, so a latch set on this edge is kept
            next_state.thermalLatch = 1'b0;
        end
        // R12: blanking masks limit; R8: start off interval
        if (wantDrive && limitHit &&
            state.blankCount == hbridge_pkg::BLANK_RESET &&
            state.offCount == hbridge_pkg::OFF_RESET) begin
            next_state.offCount = 11'(hbridge_pkg::OFF_CYCLES);
        end
        if (next_state.offCount != hbridge_pkg::OFF_RESET) begin
            wantDrive = 1'b0;
        end
        // R1: follow polarity inputs
        next_state.outA.level = wantDrive && syncA;
        next_state.outB.level = wantDrive && syncB;
        next_state.outA.drive = wantDrive;
        next_state.outB.drive = wantDrive;
        next_state.prevA = next_state.outA.level;
        next_state.prevB = next_state.outB.level;
        next_state.prevDrive = wantDrive;
        // R12: restart blanking at each output transition
        if (next_state.outA.level != state.prevA ||
            next_state.outB.level != state.prevB ||
            wantDrive != state.prevDrive) begin
            next_state.blankCount = 8'(hbridge_pkg::BLANK_CYCLES);
        end
        // R2: R3: R4: flag low on disable, under-voltage or latch
        next_state.flagLow =
            (next_state.mode == hbridge_pkg::ST_LATCHED) ||
            (next_state.mode == hbridge_pkg::ST_DISABLED) ||
            (sense.underVoltage && next_state.mode != hbridge_pkg::ST_SLEEP);
        // registered status copies, so no decode glitches reach the pins
        next_state.awake = (next_state.mode != hbridge_pkg::ST_SLEEP);
        next_state.offActive =
            (next_state.offCount != hbridge_pkg::OFF_RESET);
        next_state.thermalEvent = next_state.thermalLatch &&
            (next_state.mode == hbridge_pkg::ST_LATCHED);
    end

    // R7: power cycle clears everything
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign bridgeOutA = state.outA;
    assign bridgeOutB = state.outB;
    assign faultFlagLowOut = 1'b0;
    assign faultFlagLowOe = state.flagLow;
    assign sleepMode = !state.awake;
    assign limitOff = state.offActive;
    assign thermalLimitEvent = state.thermalEvent;
endmodule
`default_nettype wire

/* File: verification/hbridge_sva.sv */
`default_nettype none
module hbridge_sva (
    input wire logic mclk,
    input wire logic resetn,
    input wire hbridge_pkg::ctrl_t ctrlIn,
    input wire hbridge_pkg::sense_t sense,
    input wire hbridge_pkg::half_t bridgeOutA,
    input wire hbridge_pkg::half_t bridgeOutB,
    input wire logic faultFlagLowOe,
    input wire logic sleepMode,
    input wire logic limitOff
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [10:0] offLen;
    wire logic drv = bridgeOutA.drive | bridgeOutB.drive;
    wire logic stop = ctrlIn.disableHighIn & ctrlIn.enableSleepLowIn;
    wire logic hit = sense.shortCircuit & ~sleepMode;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // off window length, judged only when it closes
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) offLen <= 11'h000;
        else offLen <= limitOff ? offLen + 11'h001 : 11'h000;
    end
    drv_flag_a: assert property (drv |-> !faultFlagLowOe)
        else $error("bridge driven with flag low");
    out_follow_a:
        assert property ($stable(ctrlIn)[*4] ##0 bridgeOutA.drive
            |-> bridgeOutA.level == ctrlIn.polarityInA)
        else $error("output A level wrong");
    dis_off_a: assert property (stop[*4] |-> faultFlagLowOe && !drv)
        else $error("disable did not tri-state");
    sleep_quiet_a:
        assert property (sleepMode |-> !drv && !faultFlagLowOe)
        else $error("sleep not quiet");
    uv_off_a:
        assert property (sense.underVoltage && !sleepMode
            |=> faultFlagLowOe && !drv) else $error("under-voltage missed");
    short_latch_a: assert property (hit |=> faultFlagLowOe && !drv)
        else $error("short not latched");
    latch_clear_a:
        assert property ($fell(ctrlIn.disableHighIn) && stop == 1'b0
            && ctrlIn.enableSleepLowIn && sense[6:4] == 3'h0
            |-> ##[1:4] !faultFlagLowOe) else $error("latch not cleared");
    limit_off_a: assert property (limitOff |-> !drv)
        else $error("drive during off time");
    off_len_a:
        assert property ($fell(limitOff)
            |-> offLen == 11'(hbridge_pkg::OFF_CYCLES))
        else $error("off time length wrong");
    cover property ($rose(limitOff));
    cover property ($fell(faultFlagLowOe));
    cover property ($fell(sleepMode));
endmodule
bind hbridge_gate_control hbridge_sva chk_u (.mclk, .resetn, .ctrlIn,
    .sense, .bridgeOutA, .bridgeOutB, .faultFlagLowOe, .sleepMode,
    .limitOff);
`default_nettype wire

/* File: verification/host_model.sv */
`default_nettype none
module host_model (
    input wire hbridge_pkg::ctrl_t cmd,
    input wire logic enFloat,
    input wire logic flagOut,
    input wire logic flagOe,
    output hbridge_pkg::ctrl_t ctrlOut,
    output logic faultLine
);
    timeunit 1ns;
    timeprecision 100ps;
    always_comb begin
        ctrlOut = cmd;
        if (enFloat) ctrlOut.enableSleepLowIn = 1'b0;
    end
    // open drain flag, pull-up on the host side
    assign faultLine = flagOe ? flagOut : 1'b1;
endmodule
`default_nettype wire

/* File: verification/hbridge_gate_control_bench.sv */
`default_nettype none
module hbridge_gate_control_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic enFloat = 1'b0;
    int err_total = 0;
    int checks = 0;
    int ticks = 0;
    int n;
    hbridge_pkg::ctrl_t cmd = '0;
    hbridge_pkg::ctrl_t ctrlIn;
    hbridge_pkg::sense_t sense = 7'h08;
    hbridge_pkg::half_t outA, outB;
    logic flagOut, flagOe, sleepMode, limitOff, thermEv, faultLine;
    host_model host_u (.cmd(cmd), .enFloat(enFloat), .flagOut(flagOut),
        .flagOe(flagOe), .ctrlOut(ctrlIn), .faultLine(faultLine));
    hbridge_gate_control dut_u (.mclk(mclk), .resetn(resetn),
        .ctrlIn(ctrlIn), .sense(sense), .bridgeOutA(outA),
        .bridgeOutB(outB), .faultFlagLowOut(flagOut),
        .faultFlagLowOe(flagOe), .sleepMode(sleepMode),
        .limitOff(limitOff), .thermalLimitEvent(thermEv));
    always #10 mclk = ~mclk;
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge mclk) begin
        ticks <= ticks + 1;
        if (ticks == 20000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [10:0] e, g);
        checks++;
        if (e !== g) begin
            err_total++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    // e: drive A, level A, drive B, level B, flag line
    task automatic st(input string nm, input logic [4:0] e);
        chk(nm, 11'(e), 11'({outA.drive, outA.drive & outA.level,
            outB.drive, outB.drive & outB.level, faultLine}));
    endtask
    task automatic put(input logic [3:0] c);
        cmd = c;
        cyc(6);
    endtask
    task automatic hit(input int k);
        sense[k] = 1'b1;
        cyc(1);
        sense[k] = 1'b0;
        cyc(2);
    endtask
    task automatic t_modes();
        for (int i = 0; i < 4; i++) begin
            put({i[1:0], 2'b01});
            st("run", {1'b1, i[1], 1'b1, i[0], 1'b1});
        end
        put(4'h3);
        st("disable", 5'h00);
        put(4'h8);
        st("sleep", 5'h01);
        chk("sleepMode", 11'h001, 11'(sleepMode));
        put(4'h9);
        enFloat = 1'b1;
        cyc(6);
        st("float", 5'h01);
        enFloat = 1'b0;
        cyc(6);
        sense.underVoltage = 1'b1;
        cyc(2);
        st("uv", 5'h00);
        sense.underVoltage = 1'b0;
        cyc(2);
        st("uv gone", 5'h1d);
        $display("test modes done");
    endtask
    task automatic t_latch();
        hit(5);
        put(4'h5);
        st("latched", 5'h00);
        put(4'h7);
        put(4'h5);
        st("clear dis", 5'h17);
        hit(5);
        put(4'h4);
        put(4'h5);
        st("clear en", 5'h17);
        hit(5);
        resetn = 1'b0;
        cyc(3);
        resetn = 1'b1;
        cyc(6);
        st("power", 5'h17);
        sense.tempBelowRestart = 1'b0;
        hit(4);
        st("hot", 5'h00);
        chk("thermal", 11'h001, 11'(thermEv));
        put(4'h7);
        put(4'h5);
        st("still hot", 5'h01);
        sense.tempBelowRestart = 1'b1;
        put(4'h7);
        put(4'h5);
        st("cooled", 5'h17);
        $display("test latch done");
    endtask
    task automatic t_limit();
        put(4'h9);
        sense.currentAtNormalLimit = 1'b1;
        cyc(40);
        chk("blank", 11'h000, 11'(limitOff));
        sense.currentAtNormalLimit = 1'b0;
        cyc(100);
        sense.currentAtNormalLimit = 1'b1;
        cyc(1);
        sense.currentAtNormalLimit = 1'b0;
        st("off", 5'h01);
        for (n = 0; limitOff === 1'b1 && n < 2000; n++) cyc(1);
        chk("off len", 11'(hbridge_pkg::OFF_CYCLES), 11'(n));
        st("resume", 5'h1d);
        cyc(100);
        // foldback held only a few cycles by the host
        sense.currentAtReducedLimit = 1'b1;
        cyc(2);
        chk("cool", 11'h000, 11'(limitOff));
        sense.tempAboveFoldback = 1'b1;
        cyc(2);
        chk("fold", 11'h001, 11'(limitOff));
        sense = 7'h08;
        $display("test limit done");
    endtask
    initial begin
        cyc(3);
        resetn = 1'b1;
        t_modes();
        t_latch();
        t_limit();
        stop_test();
    end
endmodule
`default_nettype wire
